/* File: hdl/bfrdr_consts.vh */
// Purpose: Constants of the bridge fault recovery and diagnostic register block.
// Assumes: A 250 MHz core clock and a 24-bit serial frame, most significant bit first.
// Notes: Definitions only; every offset, field position, reset value and time is here.
`ifndef BFRDR_CONSTS_VH
`define BFRDR_CONSTS_VH

// ------------------------------------------------------------------
// Clock rate and times.
// ------------------------------------------------------------------
`define BFRDR_CLK_MHZ 250
`define BFRDR_OC_SLOW_US 1000
`define BFRDR_OC_FAST_US 100
`define BFRDR_ULD_FILTER_US 200
`define BFRDR_OC_SLOW_CYC (`BFRDR_OC_SLOW_US * `BFRDR_CLK_MHZ)
`define BFRDR_OC_FAST_CYC (`BFRDR_OC_FAST_US * `BFRDR_CLK_MHZ)
`define BFRDR_ULD_FILTER_CYC (`BFRDR_ULD_FILTER_US * `BFRDR_CLK_MHZ)

// ------------------------------------------------------------------
// Register offsets and reset value.
// ------------------------------------------------------------------
`define BFRDR_ADDR_CTRL 6'h03
`define BFRDR_ADDR_OC 6'h10
`define BFRDR_ADDR_ULD 6'h11
`define BFRDR_ADDR_SUP 6'h12
`define BFRDR_REG_RESET 16'h0000

// ------------------------------------------------------------------
// Field positions.
// ------------------------------------------------------------------
`define BFRDR_CTRL_SPEED_BIT 5
`define BFRDR_CTRL_SUPDIS_BIT 4
`define BFRDR_CTRL_SENSE_MSB 2
`define BFRDR_CTRL_SENSE_LSB 0
`define BFRDR_FLAG_MSB 9
`define BFRDR_FLAG_LSB 6
`define BFRDR_SUP_UV_BIT 3
`define BFRDR_SUP_OV_BIT 2
`define BFRDR_SENSE_OUT_ONE 3'h3
`define BFRDR_SENSE_OUT_TWO 3'h4

// ------------------------------------------------------------------
// Serial frame layout.
// ------------------------------------------------------------------
`define BFRDR_FRAME_BITS 24
`define BFRDR_CMD_WR_BIT 23
`define BFRDR_CMD_RC_BIT 22
`define BFRDR_CMD_ADDR_MSB 21
`define BFRDR_CMD_ADDR_LSB 16
`define BFRDR_GLB_COMBINED_BIT 7
`define BFRDR_GLB_ULD_BIT 6

`endif

/* File: hdl/bfrdr_top.v */
// Purpose: Fault recovery, current sense select and diagnostic status of two half bridges.
// Assumes: Serial port lines and fault comparators are asynchronous to clock_i.
// Notes: Switch index 3..0 is high side one, low side one, high side two, low side two.
//
// Notes on behaviour
// [RQ1] Speed field 0 slow, 1 fast recovery.
// [RQ2] Auto recovery re-enables tripped output after delay.
// [RQ3] Supply recovery field 0 auto, 1 disabled.
// [RQ4] Disabled: outputs wait until host clears flag.
// [RQ5] Selected high-side current goes to shared pin.
// [RQ6] Pin driven only for codes three and four.
// [RQ7] Overcurrent sets own bit, switches output off.
// [RQ8] Overcurrent also sets combined summary flag.
// [RQ9] Without auto recovery, host clears and re-enables.
// [RQ10] Underload checked only while switch is on.
// [RQ11] Underload bit needs continuous low current filter time.
// [RQ12] Four underload bits sit at nine down to six.
// [RQ13] Underload event also sets global underload flag.
// [RQ14] Suppress setting blocks only the global underload flag.
// [RQ15] Supply fault turns all outputs off, sets flag.
// [RQ16] Recovery enabled: outputs return when supply normal.
// [RQ17] Per-output auto recovery enables, default off; the code has one enable per half bridge.
// [RQ18] Status bits sticky, cleared by read-and-clear.
// [RQ19] Registers reset to zero; reserved bits ignore writes.
`timescale 1ns/1ns
`include "bfrdr_consts.vh"

module bfrdr_top
#(
    parameter CNT_W = 18,
    parameter [17:0] OC_SLOW_CYC = `BFRDR_OC_SLOW_CYC,
    parameter [17:0] OC_FAST_CYC = `BFRDR_OC_FAST_CYC,
    parameter [17:0] ULD_FILTER_CYC = `BFRDR_ULD_FILTER_CYC
)
(
    input wire clock_i,
    input wire resetn_i,
    input wire link_sclk_i,
    input wire link_csn_i,
    input wire link_sdi_i,
    output wire link_sdo_o,
    output wire link_sdo_oe_o,
    input wire [3:0] switch_on_req_i,
    input wire [1:0] auto_oc_recovery_enable_i,
    input wire underload_summary_suppress_i,
    input wire [3:0] switch_overcurrent_i,
    input wire [3:0] switch_undercurrent_i,
    input wire supply_overvoltage_i,
    input wire supply_undervoltage_i,
    output wire [3:0] switch_gate_en_o,
    output wire sense_out_pwm_shared_pin_oe_o,
    output wire sense_out_sel_two_o,
    output wire combined_fault_summary_flag_o,
    output wire underload_summary_flag_o
);

    // ------------------------------------------------------------------
    // Helpers.
    // ------------------------------------------------------------------
    // Picks the recovery delay for the chosen speed.
    function [CNT_W-1:0] oc_delay;
        input fast;
        begin
            oc_delay = fast ? OC_FAST_CYC[CNT_W-1:0] : OC_SLOW_CYC[CNT_W-1:0];
        end
    endfunction

    // ------------------------------------------------------------------
    // Input synchronisers.
    // ------------------------------------------------------------------
    reg [12:0] sync1_ff;
    reg [12:0] sync2_ff;
    reg sclk_d_ff;
    wire [12:0] async_in;
    wire sclk_s;
    wire csn_s;
    wire sdi_s;
    wire [3:0] oc_s;
    wire [3:0] uc_s;
    wire ov_s;
    wire uv_s;
    assign async_in = {link_sclk_i, link_csn_i, link_sdi_i, switch_overcurrent_i,
                       switch_undercurrent_i, supply_overvoltage_i, supply_undervoltage_i};
    assign {sclk_s, csn_s, sdi_s, oc_s, uc_s, ov_s, uv_s} = sync2_ff;

    // Two stages keep metastability off every downstream gate.
    always @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            sync1_ff <= 13'h0800; // Frame select idles high so no false frame start follows reset.
            sync2_ff <= 13'h0800;
            sclk_d_ff <= 1'b0;
        end
        else
        begin
            sync1_ff <= async_in;
            sync2_ff <= sync1_ff;
            sclk_d_ff <= sclk_s;
        end
    end

    wire sclk_rise = sclk_s & ~sclk_d_ff;
    wire sclk_fall = ~sclk_s & sclk_d_ff;

    // ------------------------------------------------------------------
    // Registers and serial frame.
    // ------------------------------------------------------------------
    reg oc_speed_fast_ff;
    reg supply_fault_recovery_disable_ff;
    reg [2:0] sense_mux_select_ff;
    reg [3:0] switch_overcurrent_flag_ff;
    reg [3:0] switch_underload_flag_ff;
    reg supply_overvoltage_flag_ff;
    reg supply_undervoltage_flag_ff;
    reg [23:0] rx_shift_ff;
    reg [23:0] tx_shift_ff;
    reg [4:0] bit_cnt_ff;
    reg [15:0] resp_data_ff;
    reg csn_d_ff;
    reg sdo_ff;
    reg sdo_oe_ff;
    reg combined_ff;
    reg uld_summary_ff;

    wire frame_start = ~csn_s & csn_d_ff;
    wire frame_end = csn_s & ~csn_d_ff & (bit_cnt_ff == 5'd24);
    wire [23:0] cmd = rx_shift_ff;
    wire [5:0] cmd_addr = cmd[`BFRDR_CMD_ADDR_MSB:`BFRDR_CMD_ADDR_LSB];
    wire cmd_wr = frame_end & cmd[`BFRDR_CMD_WR_BIT];
    wire cmd_rc = frame_end & cmd[`BFRDR_CMD_RC_BIT];

    // Readback value of the addressed register; unused positions read zero.
    reg [15:0] rd_data;
    always @*
    begin
        rd_data = `BFRDR_REG_RESET;
        case (cmd_addr)
            `BFRDR_ADDR_CTRL:
            begin
                rd_data[`BFRDR_CTRL_SPEED_BIT] = oc_speed_fast_ff;
                rd_data[`BFRDR_CTRL_SUPDIS_BIT] = supply_fault_recovery_disable_ff;
                rd_data[`BFRDR_CTRL_SENSE_MSB:`BFRDR_CTRL_SENSE_LSB] = sense_mux_select_ff;
            end
            `BFRDR_ADDR_OC: rd_data[`BFRDR_FLAG_MSB:`BFRDR_FLAG_LSB] = switch_overcurrent_flag_ff;
            `BFRDR_ADDR_ULD: rd_data[`BFRDR_FLAG_MSB:`BFRDR_FLAG_LSB] = switch_underload_flag_ff; // RQ12
            `BFRDR_ADDR_SUP:
            begin
                rd_data[`BFRDR_SUP_UV_BIT] = supply_undervoltage_flag_ff;
                rd_data[`BFRDR_SUP_OV_BIT] = supply_overvoltage_flag_ff;
            end
            default: rd_data = `BFRDR_REG_RESET;
        endcase
    end

    // Clear masks: only bits that were actually reported get cleared.
    wire [3:0] oc_clr = (cmd_rc && cmd_addr == `BFRDR_ADDR_OC) ?
                        rd_data[`BFRDR_FLAG_MSB:`BFRDR_FLAG_LSB] : 4'h0; // RQ18
    wire [3:0] uld_clr = (cmd_rc && cmd_addr == `BFRDR_ADDR_ULD) ?
                         rd_data[`BFRDR_FLAG_MSB:`BFRDR_FLAG_LSB] : 4'h0; // RQ18
    wire sup_rc = cmd_rc && cmd_addr == `BFRDR_ADDR_SUP;
    wire ov_clr = sup_rc & rd_data[`BFRDR_SUP_OV_BIT];
    wire uv_clr = sup_rc & rd_data[`BFRDR_SUP_UV_BIT];

    // Shift engine: sample on rising, shift out on falling; the answer is the
    // word captured at the end of the previous frame, so it is ready at once.
    always @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            csn_d_ff <= 1'b1;
            rx_shift_ff <= 24'h000000;
            tx_shift_ff <= 24'h000000;
            bit_cnt_ff <= 5'h00;
            resp_data_ff <= `BFRDR_REG_RESET;
            sdo_ff <= 1'b0;
            sdo_oe_ff <= 1'b0;
        end
        else
        begin
            csn_d_ff <= csn_s;
            sdo_oe_ff <= ~csn_s;
            if (frame_start)
            begin
                tx_shift_ff <= {combined_ff, uld_summary_ff, 6'h00, resp_data_ff};
                sdo_ff <= combined_ff;
                bit_cnt_ff <= 5'h00;
            end
            else if (!csn_s && sclk_rise)
            begin
                rx_shift_ff <= {rx_shift_ff[22:0], sdi_s};
                // Saturating past 24 keeps an overlong frame from looking complete.
                if (bit_cnt_ff != 5'h1F)
                    bit_cnt_ff <= bit_cnt_ff + 5'h01;
            end
            else if (!csn_s && sclk_fall)
            begin
                tx_shift_ff <= {tx_shift_ff[22:0], 1'b0};
                sdo_ff <= tx_shift_ff[22];
            end
            // A frame of any other length is dropped without effect.
            if (frame_end)
                resp_data_ff <= rd_data;
        end
    end

    // Control register: only its five documented bits take writes.
    always @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            oc_speed_fast_ff <= 1'b0; // RQ19
            supply_fault_recovery_disable_ff <= 1'b0;
            sense_mux_select_ff <= 3'h0;
        end
        else if (cmd_wr && cmd_addr == `BFRDR_ADDR_CTRL)
        begin
            oc_speed_fast_ff <= cmd[`BFRDR_CTRL_SPEED_BIT]; // RQ1
            supply_fault_recovery_disable_ff <= cmd[`BFRDR_CTRL_SUPDIS_BIT]; // RQ3
            sense_mux_select_ff <= cmd[`BFRDR_CTRL_SENSE_MSB:`BFRDR_CTRL_SENSE_LSB];
        end
    end

    // ------------------------------------------------------------------
    // Overcurrent latch and automatic recovery.
    // ------------------------------------------------------------------
    reg [3:0] oc_off_ff;
    reg [CNT_W-1:0] rec_cnt_ff [0:1];
    reg [1:0] rec_done;
    integer k;
    integer j;
    integer n;
    integer u;

    // One timer per half bridge; it restarts whenever that bridge is not tripped.
    always @*
    begin
        for (k = 0; k < 2; k = k + 1)
            rec_done[k] = (rec_cnt_ff[k] >= oc_delay(oc_speed_fast_ff) - 1'b1); // RQ1
    end

    always @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            rec_cnt_ff[0] <= {CNT_W{1'b0}};
            rec_cnt_ff[1] <= {CNT_W{1'b0}};
        end
        else
        begin
            for (j = 0; j < 2; j = j + 1)
                if ((oc_off_ff[2*j+1] | oc_off_ff[2*j]) & auto_oc_recovery_enable_i[j] &
                    ~rec_done[j])
                    rec_cnt_ff[j] <= rec_cnt_ff[j] + 1'b1; // RQ17
                else
                    rec_cnt_ff[j] <= {CNT_W{1'b0}};
        end
    end

    // Trip wins over release; the auto path releases after the delay, the manual
    // path once the host has read the flag away.
    always @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            oc_off_ff <= 4'h0;
            switch_overcurrent_flag_ff <= 4'h0;
        end
        else
        begin
            for (n = 0; n < 4; n = n + 1)
            begin
                if (oc_s[n])
                    oc_off_ff[n] <= 1'b1; // RQ7
                else if (auto_oc_recovery_enable_i[n/2] ? rec_done[n/2] : // RQ2
                         ~switch_overcurrent_flag_ff[n])
                    oc_off_ff[n] <= 1'b0; // RQ9
            end
            switch_overcurrent_flag_ff <= oc_s | (switch_overcurrent_flag_ff & ~oc_clr); // RQ7
        end
    end

    // ------------------------------------------------------------------
    // Supply fault handling.
    // ------------------------------------------------------------------
    // With recovery disabled the flag itself holds the outputs off.
    wire supply_off = ov_s | uv_s | // RQ15
        (supply_fault_recovery_disable_ff &
         (supply_overvoltage_flag_ff | supply_undervoltage_flag_ff)); // RQ4

    always @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            supply_overvoltage_flag_ff <= 1'b0;
            supply_undervoltage_flag_ff <= 1'b0;
        end
        else
        begin
            supply_overvoltage_flag_ff <= ov_s | (supply_overvoltage_flag_ff & ~ov_clr); // RQ15
            supply_undervoltage_flag_ff <= uv_s | (supply_undervoltage_flag_ff & ~uv_clr);
        end
    end

    // ------------------------------------------------------------------
    // Gate drive, underload filter and sense routing.
    // ------------------------------------------------------------------
    reg [3:0] gate_en_ff;
    reg [CNT_W-1:0] uld_cnt_ff [0:3];
    reg sense_oe_ff;
    reg sense_two_ff;

    // With supply recovery enabled, outputs come back by themselves once the supply is normal again.
    always @(posedge clock_i)
    begin
        if (!resetn_i)
            gate_en_ff <= 4'h0;
        else
            gate_en_ff <= switch_on_req_i & ~oc_off_ff & ~oc_s & {4{~supply_off}}; // RQ16
    end

    // The filter counts only while the switch is on and the current stays low;
    // any gap restarts it.
    always @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            for (u = 0; u < 4; u = u + 1)
                uld_cnt_ff[u] <= {CNT_W{1'b0}};
            switch_underload_flag_ff <= 4'h0;
        end
        else
        begin
            for (u = 0; u < 4; u = u + 1)
            begin
                if (gate_en_ff[u] & uc_s[u]) // RQ10
                begin
                    if (uld_cnt_ff[u] != ULD_FILTER_CYC[CNT_W-1:0])
                        uld_cnt_ff[u] <= uld_cnt_ff[u] + 1'b1;
                end
                else
                    uld_cnt_ff[u] <= {CNT_W{1'b0}};
                switch_underload_flag_ff[u] <=
                    (uld_cnt_ff[u] == ULD_FILTER_CYC[CNT_W-1:0]) | // RQ11
                    (switch_underload_flag_ff[u] & ~uld_clr[u]);
            end
        end
    end

    // Summaries, and the shared pin driven only while a valid stage is chosen.
    always @(posedge clock_i)
    begin
        if (!resetn_i)
        begin
            combined_ff <= 1'b0;
            uld_summary_ff <= 1'b0;
            sense_oe_ff <= 1'b0;
            sense_two_ff <= 1'b0;
        end
        else
        begin
            combined_ff <= (|switch_overcurrent_flag_ff) | supply_overvoltage_flag_ff |
                           supply_undervoltage_flag_ff; // RQ8
            uld_summary_ff <= (|switch_underload_flag_ff) & ~underload_summary_suppress_i; // RQ13 RQ14
            sense_oe_ff <= (sense_mux_select_ff == `BFRDR_SENSE_OUT_ONE) |
                           (sense_mux_select_ff == `BFRDR_SENSE_OUT_TWO); // RQ6
            sense_two_ff <= (sense_mux_select_ff == `BFRDR_SENSE_OUT_TWO); // RQ5
        end
    end

    assign link_sdo_o = sdo_ff;
    assign link_sdo_oe_o = sdo_oe_ff;
    assign switch_gate_en_o = gate_en_ff;
    assign sense_out_pwm_shared_pin_oe_o = sense_oe_ff;
    assign sense_out_sel_two_o = sense_two_ff;
    assign combined_fault_summary_flag_o = combined_ff;
    assign underload_summary_flag_o = uld_summary_ff;

endmodule // bfrdr_top

/* File: tb/bfrdr_checker.sv */
// Purpose: Port-level checks of fault, sense and underload behaviour.
// Assumes: One clock domain; shortened counts handed in by the bind.
// Notes: Margins of a few cycles cover the input synchronisers.
`timescale 1ns/1ns
module bfrdr_checker
#(
    parameter [17:0] ULD_FILTER_CYC = 18'h00014
)
(
    input wire clock_i,
    input wire resetn_i,
    input wire link_csn_i,
    input wire [3:0] switch_on_req_i,
    input wire underload_summary_suppress_i,
    input wire [3:0] switch_overcurrent_i,
    input wire [3:0] switch_undercurrent_i,
    input wire supply_overvoltage_i,
    input wire supply_undervoltage_i,
    input wire [3:0] switch_gate_en_o,
    input wire sense_out_pwm_shared_pin_oe_o,
    input wire sense_out_sel_two_o,
    input wire combined_fault_summary_flag_o,
    input wire underload_summary_flag_o
);
    // ------------------------------------------------------------
    // Helper logic and properties.
    // ------------------------------------------------------------
    reg [17:0] uld_run_ff;
    wire [17:0] nxt_uld_run;
    wire low_load;
    wire sup_bad;
    genvar k;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // Raw run of low current on any switch that is on; it saturates.
    assign low_load = |(switch_undercurrent_i & switch_gate_en_o);
    assign sup_bad = supply_overvoltage_i | supply_undervoltage_i;
    assign nxt_uld_run = !low_load ? 18'h00000 : uld_run_ff + {17'h00000, ~&uld_run_ff};
    // The run restarts in reset so a stale count never arms a check.
    always @(posedge clock_i)
    begin
        if (!resetn_i)
            uld_run_ff <= 18'h00000;
        else
            uld_run_ff <= nxt_uld_run;
    end
    // Per switch: a held trip must turn the gate off and raise the summary.
    generate
        for (k = 0; k < 4; k = k + 1)
        begin : g_sw
            AST_OC_GATE_OFF: assert property (switch_overcurrent_i[k] [*7] |-> !switch_gate_en_o[k])
                else $error("gate on during overcurrent");
            AST_OC_SUMMARY: assert property (switch_overcurrent_i[k] [*7] |-> combined_fault_summary_flag_o)
                else $error("summary low after overcurrent");
        end
    endgenerate
    AST_SUP_OFF: assert property (sup_bad [*7] |-> switch_gate_en_o == 4'h0)
        else $error("gates on during supply fault");
    AST_SUP_FLAG: assert property (sup_bad [*7] |-> combined_fault_summary_flag_o)
        else $error("summary low during supply fault");
    AST_GATE_REQ: assert property ((switch_gate_en_o & ~$past(switch_on_req_i) & ~$past(switch_on_req_i, 2)) == 4'h0)
        else $error("gate on without request");
    AST_ULD_SUPPRESS: assert property (underload_summary_suppress_i [*3] |-> !underload_summary_flag_o)
        else $error("underload summary while suppressed");
    AST_ULD_FILTER: assert property (uld_run_ff == 18'h00001 && !underload_summary_flag_o |=> !underload_summary_flag_o [*8])
        else $error("underload flagged before filter time");
    AST_ULD_SETS: assert property (uld_run_ff >= ULD_FILTER_CYC + 18'h0000A && !underload_summary_suppress_i |-> underload_summary_flag_o)
        else $error("underload summary missing");
    AST_SENSE_STABLE: assert property (link_csn_i [*8] |=> $stable(sense_out_pwm_shared_pin_oe_o) && $stable(sense_out_sel_two_o))
        else $error("sense select moved without a frame");
    COV_OC_TRIP: cover property ($fell(switch_gate_en_o[3]));
    COV_ULD: cover property ($rose(underload_summary_flag_o));
    COV_SUP: cover property (sup_bad ##1 switch_gate_en_o == 4'h0);
endmodule // bfrdr_checker

/* File: tb/bfrdr_host.sv */
// Purpose: Host end of the serial register link, one frame per call.
// Assumes: The link clock idles low and stands still between frames.
// Notes: A half period of 16 core clocks comes close to a 125 ns link period.
`timescale 1ns/1ns
module bfrdr_host
#(
    parameter integer HALF = 16
)
(
    input wire clock_i,
    input wire link_sdo_i,
    input wire link_sdo_oe_i,
    output reg link_sclk_o,
    output reg link_csn_o,
    output reg link_sdi_o
);
    // ------------------------------------------------------------
    // Frame engine.
    // ------------------------------------------------------------
    // Idle levels at time zero.
    initial
    begin
        link_sclk_o = 1'h0;
        link_csn_o = 1'h1;
        link_sdi_o = 1'h0;
    end
    // Data moves with the falling link clock so it is settled at the rise.
    task automatic xfer(input [23:0] cmd, output [23:0] rsp);
        integer k;
        begin
            @(posedge clock_i);
            link_csn_o <= 1'h0;
            for (k = 23; k >= 0; k = k - 1)
            begin
                link_sdi_o <= cmd[k];
                repeat (HALF) @(posedge clock_i);
                link_sclk_o <= 1'h1;
                rsp[k] = link_sdo_oe_i ? link_sdo_i : 1'hx;
                repeat (HALF) @(posedge clock_i);
                link_sclk_o <= 1'h0;
            end
            repeat (HALF) @(posedge clock_i);
            link_csn_o <= 1'h1;
            // An unqualified line shows the inverse of its last bit.
            link_sdi_o <= ~cmd[0];
            repeat (8) @(posedge clock_i);
        end
    endtask
endmodule // bfrdr_host

/* File: tb/bfrdr_top_tb.sv */
// Purpose: Self-checking bench of the fault recovery and diagnostic block.
// Assumes: Shortened counts; the host model runs one frame at a time.
// Notes: Timing windows leave room for the input synchronisers.
`timescale 1ns/1ns
`include "bfrdr_consts.vh"
module bfrdr_top_tb;
    // ------------------------------------------------------------
    // Stimulus, instances and tasks.
    // ------------------------------------------------------------
    localparam [17:0] ULDF = 18'h00014;
    reg clock_i;
    reg resetn_i;
    reg [3:0] req;
    reg [1:0] auto;
    reg sup;
    reg [3:0] oc;
    reg [3:0] uc;
    reg ov;
    reg uv;
    wire sclk, csn, sdi, sdo, sdo_oe, s_oe, s_two, comb, uldf;
    wire [3:0] gate;
    wire [15:0] st;
    integer n_errors;
    integer comparisons;
    integer i;
    reg [23:0] r;
    // Summary flags and gates viewed as one word.
    assign st = {10'h000, comb, uldf, gate};
    bfrdr_top #(.OC_SLOW_CYC(18'h00028), .OC_FAST_CYC(18'h0000A), .ULD_FILTER_CYC(ULDF)) uut (
        .clock_i(clock_i), .resetn_i(resetn_i), .link_sclk_i(sclk), .link_csn_i(csn),
        .link_sdi_i(sdi), .link_sdo_o(sdo), .link_sdo_oe_o(sdo_oe), .switch_on_req_i(req),
        .auto_oc_recovery_enable_i(auto), .underload_summary_suppress_i(sup),
        .switch_overcurrent_i(oc), .switch_undercurrent_i(uc), .supply_overvoltage_i(ov),
        .supply_undervoltage_i(uv), .switch_gate_en_o(gate), .sense_out_pwm_shared_pin_oe_o(s_oe),
        .sense_out_sel_two_o(s_two), .combined_fault_summary_flag_o(comb),
        .underload_summary_flag_o(uldf));
    bfrdr_host host (.clock_i(clock_i), .link_sdo_i(sdo), .link_sdo_oe_i(sdo_oe),
        .link_sclk_o(sclk), .link_csn_o(csn), .link_sdi_o(sdi));
    task cyc(input integer n);
        repeat (n) @(posedge clock_i);
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp)
            begin
                n_errors = n_errors + 1;
                $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [5:0] a, input [15:0] d);
        host.xfer({1'h1, 1'h0, a, d}, r);
    endtask
    // The answer to a read arrives in the following frame.
    task rd(input [5:0] a, input c, input [15:0] e);
        begin
            host.xfer({1'h0, c, a, 16'h0000}, r);
            host.xfer(24'h000000, r);
            chk(r[15:0], e);
        end
    endtask
    task test_done;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, n_errors);
            if (n_errors == 0 && comparisons > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    // Free-running core clock.
    initial
    begin
        clock_i = 1'h0;
        forever #2 clock_i = ~clock_i;
    end
    // A hang counts as a mismatch.
    initial
    begin
        cyc(60000);
        n_errors = n_errors + 1;
        test_done;
    end
    // Main sequence.
    initial
    begin
        n_errors = 0;
        comparisons = 0;
        {resetn_i, req, auto, sup, oc, uc, ov, uv} = 18'h00000;
        cyc(3);
        resetn_i <= 1'h1;
        cyc(4);
        chk(st, 16'h0000);
        rd(`BFRDR_ADDR_CTRL, 1'h0, 16'h0000);
        rd(`BFRDR_ADDR_OC, 1'h0, 16'h0000);
        rd(`BFRDR_ADDR_ULD, 1'h0, 16'h0000);
        rd(6'h20, 1'h0, 16'h0000);
        wr(`BFRDR_ADDR_CTRL, 16'hFFFF);
        rd(`BFRDR_ADDR_CTRL, 1'h0, 16'h0037);
        $display("test reset done");
        for (i = 0; i < 8; i = i + 1)
        begin
            wr(`BFRDR_ADDR_CTRL, i[15:0]);
            cyc(8);
            chk({14'h0000, s_oe, s_two & s_oe}, (i == 3) ? 16'h0002 : (i == 4) ? 16'h0003 : 16'h0000);
        end
        $display("test sense done");
        req <= 4'hF;
        cyc(4);
        chk(st, 16'h000F);
        oc <= 4'h8;
        cyc(8);
        oc <= 4'h0;
        cyc(60);
        chk(st, 16'h0027);
        rd(`BFRDR_ADDR_OC, 1'h0, 16'h0200);
        chk({8'h00, r[23:16]}, 16'h0080);
        rd(`BFRDR_ADDR_OC, 1'h1, 16'h0200);
        chk(st, 16'h000F);
        rd(`BFRDR_ADDR_OC, 1'h0, 16'h0000);
        $display("test manual recovery done");
        auto <= 2'h2;
        for (i = 0; i < 2; i = i + 1)
        begin
            wr(`BFRDR_ADDR_CTRL, {10'h000, i[0], 5'h00});
            oc <= 4'h4;
            cyc(2);
            oc <= 4'h0;
            cyc(20);
            chk(st, (i == 1) ? 16'h002F : 16'h002B);
            cyc(42);
            chk(st, 16'h002F);
            rd(`BFRDR_ADDR_OC, 1'h1, 16'h0100);
        end
        oc <= 4'h2;
        cyc(2);
        oc <= 4'h0;
        cyc(62);
        chk(st, 16'h002D);
        rd(`BFRDR_ADDR_OC, 1'h1, 16'h0080);
        chk(st, 16'h000F);
        $display("test auto recovery done");
        uc <= 4'h1;
        cyc(ULDF + 20);
        uc <= 4'h0;
        chk(st, 16'h001F);
        rd(`BFRDR_ADDR_ULD, 1'h1, 16'h0040);
        chk(st, 16'h000F);
        for (i = 0; i < 2; i = i + 1)
        begin
            uc <= 4'h2;
            cyc(ULDF - 8);
            uc <= 4'h0;
            cyc(2);
        end
        cyc(30);
        chk(st, 16'h000F);
        req <= 4'hD;
        uc <= 4'h2;
        cyc(60);
        uc <= 4'h0;
        req <= 4'hF;
        cyc(4);
        rd(`BFRDR_ADDR_ULD, 1'h0, 16'h0000);
        sup <= 1'h1;
        uc <= 4'h8;
        cyc(60);
        uc <= 4'h0;
        cyc(4);
        chk(st, 16'h000F);
        rd(`BFRDR_ADDR_ULD, 1'h1, 16'h0200);
        sup <= 1'h0;
        $display("test underload done");
        ov <= 1'h1;
        cyc(8);
        chk(st, 16'h0020);
        ov <= 1'h0;
        cyc(10);
        chk(st, 16'h002F);
        rd(`BFRDR_ADDR_SUP, 1'h1, 16'h0004);
        chk(st, 16'h000F);
        wr(`BFRDR_ADDR_CTRL, 16'h0010);
        uv <= 1'h1;
        cyc(4);
        uv <= 1'h0;
        cyc(60);
        chk(st, 16'h0020);
        rd(`BFRDR_ADDR_SUP, 1'h1, 16'h0008);
        chk(st, 16'h000F);
        $display("test supply done");
        test_done;
    end
endmodule // bfrdr_top_tb
bind bfrdr_top bfrdr_checker #(.ULD_FILTER_CYC(ULD_FILTER_CYC)) chk_i (.*);
